// file: rtl/sdh_host.sv
// Our own choices: the Avalon-MM register port and the register addresses.
`include "sdh_defs.svh"
module sdh_host
  import sdh_pkg::*;
#(
  parameter int HOLD_CYC = `SDH_HOLD_US * `SDH_CLK_MHZ
)(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // memory command pins
  output logic sd_cke,
  output logic sd_cs_n,
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_we_n,
  output logic [11:0] sd_addr,
  output logic [1:0] sd_dqm,
  // memory data pins
  input wire logic [15:0] sd_dq_in,
  output logic [15:0] sd_dq_out,
  output logic sd_dq_oe_n
);
  sdh_state_e state, next_state;
  sdh_req_s req, pend;
  sdh_pins_s pins;
  sdh_bank_e bank_st [2];
  logic issue, refuse, pend_valid, closed, loaded, err, rvalid;
  logic both_idle, burst_done, bus_wr, bus_rd, cap, writing;
  logic [1:0] ref_cnt;
  logic [3:0] gap, next_gap, lat;
  logic [8:0] burst_left, blen;
  logic [15:0] hold_cnt, wdata, rdata, dq_s1, dq_s2;
  logic [12:0] mode;

  // pin encoding of row, column and write strobes
  function automatic logic [2:0] strobes(input sdh_op_e op);
    case (op)
      SDH_OP_BST: strobes = 3'h6;
      SDH_OP_READ: strobes = 3'h5;
      SDH_OP_WRITE: strobes = 3'h4;
      SDH_OP_ACT: strobes = 3'h3;
      SDH_OP_PRE: strobes = 3'h2;
      SDH_OP_REF: strobes = 3'h1;
      SDH_OP_MRS: strobes = 3'h0;
      default: strobes = 3'h7;
    endcase
  endfunction : strobes

  function automatic logic is_busy(input sdh_bank_e s);
    is_busy = (s != BK_IDLE) && (s != BK_ACTIVE);
  endfunction : is_busy

  assign both_idle = (bank_st[0] == BK_IDLE) && (bank_st[1] == BK_IDLE);
  assign bus_wr = avs_write && !avs_waitrequest;
  assign bus_rd = avs_read && !avs_waitrequest;
  assign burst_done = (burst_left == 9'h001);
  assign cap = (lat == 4'h1);

  // avalon slave: one wait cycle per access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
    end else if (ce && avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0;
      if (avs_address == `SDH_REG_STATUS) begin
        avs_readdata[`SDH_ST_INIT] <= (state != S_HOLD && state != S_INIT);
        avs_readdata[`SDH_ST_BUSY] <= pend_valid || (gap != 4'h0) || (state != S_READY);
        avs_readdata[`SDH_ST_ERR] <= err;
        avs_readdata[`SDH_ST_SLEEP] <= (state == S_SLEEP);
        avs_readdata[`SDH_ST_RVALID] <= rvalid;
        avs_readdata[`SDH_ST_BANK0] <= bank_st[0];
        avs_readdata[`SDH_ST_BANK1] <= bank_st[1];
      end else if (avs_address == `SDH_REG_MODE) begin
        avs_readdata[12:0] <= mode;
      end else if (avs_address == `SDH_REG_WDATA) begin
        avs_readdata[15:0] <= wdata;
      end else if (avs_address == `SDH_REG_RDATA) begin
        avs_readdata[15:0] <= rdata;
      end
    end
  end

  // software registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode <= {1'b0, `SDH_MODE_RESET};
      wdata <= 16'h0;
    end else if (ce && bus_wr) begin
      if (avs_address == `SDH_REG_MODE) mode <= avs_writedata[12:0];
      else if (avs_address == `SDH_REG_WDATA) wdata <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_valid <= 1'b0;
      pend <= '0;
    end else if (ce) begin
      if (bus_wr && avs_address == `SDH_REG_CMD && !pend_valid) begin
        pend_valid <= 1'b1;
        pend.op <= sdh_op_e'(avs_writedata[`SDH_CMD_OP]);
        pend.bank <= avs_writedata[`SDH_CMD_BANK];
        pend.a10 <= avs_writedata[`SDH_CMD_A10];
        pend.addr <= avs_writedata[`SDH_CMD_ADDR];
      end else if (state == S_READY && gap == 4'h0) begin
        pend_valid <= 1'b0;
      end else if (state == S_SLEEP) begin
        pend_valid <= 1'b0;
      end
    end
  end

  // error and read-valid flags: set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err <= 1'b0;
      rvalid <= 1'b0;
    end else if (ce) begin
      if (refuse || (bus_wr && avs_address == `SDH_REG_CMD && pend_valid)) err <= 1'b1;
      else if (bus_wr && avs_address == `SDH_REG_STATUS && avs_writedata[`SDH_ST_ERR])
        err <= 1'b0;
      if (cap) rvalid <= 1'b1;
      else if (bus_rd && avs_address == `SDH_REG_RDATA) rvalid <= 1'b0;
    end
  end

  // command sequencing
  always_comb begin
    next_state = state;
    next_gap = (gap != 4'h0) ? gap - 4'h1 : 4'h0;
    issue = 1'b0;
    refuse = 1'b0;
    req = '0;
    case (state)
      S_HOLD: begin
        if (hold_cnt == 16'h0) next_state = S_INIT;
      end
      S_INIT: begin
        if (gap == 4'h0) begin
          if (!closed) begin
            issue = 1'b1;
            req.op = SDH_OP_PRE;
            req.a10 = 1'b1;
          end else if (!loaded && (mode[`SDH_MODE_FIRST] || ref_cnt == `SDH_REF_INIT)) begin
            issue = 1'b1;
            req.op = SDH_OP_MRS;
            next_gap = `SDH_MRS_GAP;
          end else if (ref_cnt != `SDH_REF_INIT) begin
            issue = 1'b1;
            req.op = SDH_OP_REF;
            next_gap = `SDH_REF_GAP;
          end else begin
            next_state = S_READY;
          end
        end
      end
      S_READY: begin
        if (gap == 4'h0 && pend_valid) begin
          req = pend;
          case (pend.op)
            SDH_OP_MRS, SDH_OP_REF: refuse = !both_idle;
            SDH_OP_SLEEP: refuse = !both_idle;
            SDH_OP_ACT: refuse = (bank_st[pend.bank] != BK_IDLE);
            SDH_OP_READ, SDH_OP_WRITE: refuse = (bank_st[pend.bank] == BK_IDLE) ||
              (bank_st[pend.bank] == BK_READ_AC) || (bank_st[pend.bank] == BK_WRITE_AC);
            SDH_OP_WAKE: refuse = 1'b1;
            default: refuse = 1'b0;
          endcase
          if (!refuse) begin
            if (pend.op == SDH_OP_SLEEP) next_state = S_SLEEP;
            else issue = 1'b1;
            if (pend.op == SDH_OP_MRS) next_gap = `SDH_MRS_GAP;
            else if (pend.op == SDH_OP_REF) next_gap = `SDH_REF_GAP;
            else next_gap = `SDH_CMD_GAP;
          end
        end
      end
      S_SLEEP: begin
        if (pend_valid) begin
          refuse = (pend.op != SDH_OP_WAKE);
          if (!refuse) begin
            next_state = S_READY;
            next_gap = `SDH_WAKE_GAP;
          end
        end
      end
      default: next_state = S_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_HOLD;
      gap <= 4'h0;
    end else if (ce) begin
      state <= next_state;
      gap <= next_gap;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 16'(HOLD_CYC);
    end else if (ce && state == S_HOLD && hold_cnt != 16'h0) begin
      hold_cnt <= hold_cnt - 16'h1;
    end
  end

  // init progress
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      closed <= 1'b0;
      loaded <= 1'b0;
      ref_cnt <= 2'h0;
    end else if (ce && issue && state == S_INIT) begin
      if (req.op == SDH_OP_PRE) closed <= 1'b1;
      if (req.op == SDH_OP_MRS) loaded <= 1'b1;
      if (req.op == SDH_OP_REF) ref_cnt <= ref_cnt + 2'h1;
    end
  end

  // command pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins <= {4'hf, 12'h0};
      sd_cke <= 1'b1;
    end else if (ce) begin
      sd_cke <= (next_state != S_SLEEP);
      pins.cs_n <= !issue;
      {pins.ras_n, pins.cas_n, pins.we_n} <= issue ? strobes(req.op) : 3'h7;
      if (issue) begin
        case (req.op)
          SDH_OP_ACT: pins.addr <= {req.bank, req.addr};
          SDH_OP_READ, SDH_OP_WRITE: pins.addr <= {req.bank, req.a10, 2'h0, req.addr[7:0]};
          SDH_OP_MRS: pins.addr <= mode[`SDH_MODE_WORD];
          default: pins.addr <= {req.bank, req.a10, 10'h0};
        endcase
      end
    end
  end

  assign sd_cs_n = pins.cs_n;
  assign sd_ras_n = pins.ras_n;
  assign sd_cas_n = pins.cas_n;
  assign sd_we_n = pins.we_n;
  assign sd_addr = pins.addr;

  // burst length from the loaded word
  always_comb begin
    if (mode[`SDH_MF_BL] == `SDH_BL_FULL) blen = `SDH_FULL_PAGE;
    else blen = 9'(9'h001 << mode[`SDH_MF_BL]);
    if (req.op == SDH_OP_WRITE && mode[`SDH_MF_SINGLE]) blen = 9'h001;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      burst_left <= 9'h0;
      writing <= 1'b0;
    end else if (ce) begin
      if (issue && (req.op == SDH_OP_READ || req.op == SDH_OP_WRITE)) begin
        burst_left <= blen;
        writing <= (req.op == SDH_OP_WRITE);
      end else if (issue && (req.op == SDH_OP_BST || req.op == SDH_OP_PRE)) begin
        burst_left <= 9'h0;
        writing <= 1'b0;
      end else if (burst_left != 9'h0 && !(mode[`SDH_MF_BL] == `SDH_BL_FULL && burst_left == 9'h1)) begin
        burst_left <= burst_left - 9'h1;
        if (burst_done) writing <= 1'b0;
      end
    end
  end

  // write data and byte masks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sd_dq_out <= 16'h0;
      sd_dq_oe_n <= 1'b1;
      sd_dqm <= 2'h3;
    end else if (ce) begin
      if (issue && req.op == SDH_OP_WRITE) begin
        sd_dq_out <= wdata;
        sd_dq_oe_n <= 1'b0;
        sd_dqm <= 2'h0;
      end else if (writing && !burst_done && !issue) begin
        sd_dq_oe_n <= 1'b0;
        sd_dqm <= 2'h3;
      end else begin
        sd_dq_oe_n <= 1'b1;
        sd_dqm <= (next_state == S_HOLD) ? 2'h3 : 2'h0;
      end
    end
  end

  // read capture after latency plus pin and sync stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq_s1 <= 16'h0;
      dq_s2 <= 16'h0;
    end else if (ce) begin
      dq_s1 <= sd_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lat <= 4'h0;
      rdata <= 16'h0;
    end else if (ce) begin
      if (issue && req.op == SDH_OP_READ) lat <= {1'b0, mode[`SDH_MF_LAT]} + `SDH_PIPE_LAT;
      else if (lat != 4'h0) lat <= lat - 4'h1;
      if (cap) rdata <= dq_s2;
    end
  end

  sdh_bank_track u_track (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .issue(issue),
    .req(req),
    .burst_done(burst_done),
    .bank_st(bank_st)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !ce);

  a_hold_pins_high: assert property (state == S_HOLD |-> sd_cke && sd_dqm == 2'h3)
    else $error("clock gate or mask low during power-up hold");
  a_first_close_all: assert property (state == S_INIT && !closed && gap == 4'h0 |=>
    !sd_cs_n && !sd_ras_n && sd_cas_n && !sd_we_n && sd_addr[10])
    else $error("first init command is not close of both banks");
  a_mode_load_idle: assert property (issue && req.op == SDH_OP_MRS |-> both_idle)
    else $error("mode load issued with a bank open");
  a_mode_load_gap: assert property (!sd_cs_n && !sd_ras_n && !sd_cas_n && !sd_we_n |=>
    sd_cs_n [*2])
    else $error("command too soon after mode load");
  a_sleep_banks_idle: assert property ($fell(sd_cke) |-> $past(both_idle))
    else $error("clock gate dropped with a bank open");
  a_sleep_no_cmd: assert property (!sd_cke |-> sd_cs_n)
    else $error("command presented while clock gate low");
  a_init_complete: assert property (state == S_INIT ##1 state == S_READY |->
    loaded && ref_cnt == `SDH_REF_INIT)
    else $error("init ended without two refreshes and mode load");
  a_column_a89_zero: assert property (!sd_cs_n && sd_ras_n && !sd_cas_n |->
    sd_addr[9:8] == 2'h0)
    else $error("column phase drives address bits 8 or 9");
  a_read_capture: assert property (issue && req.op == SDH_OP_READ |-> ##[3:10] cap)
    else $error("read data not captured after latency");

  c_init_done: cover property (state == S_INIT ##1 state == S_READY);
  c_read_word: cover property (cap);
  c_sleep_wake: cover property (!sd_cke ##[1:20] sd_cke);
  c_refused: cover property (refuse);
endmodule : sdh_host

// file: include/sdh_defs.svh
`ifndef SDH_DEFS_SVH
`define SDH_DEFS_SVH

// register word indices on the avalon slave
`define SDH_REG_CMD 3'h0
`define SDH_REG_STATUS 3'h1
`define SDH_REG_MODE 3'h2
`define SDH_REG_WDATA 3'h3
`define SDH_REG_RDATA 3'h4

// command register fields
`define SDH_CMD_OP 3:0
`define SDH_CMD_BANK 4
`define SDH_CMD_A10 5
`define SDH_CMD_ADDR 18:8

// status register fields
`define SDH_ST_INIT 0
`define SDH_ST_BUSY 1
`define SDH_ST_ERR 2
`define SDH_ST_SLEEP 3
`define SDH_ST_RVALID 4
`define SDH_ST_BANK0 10:8
`define SDH_ST_BANK1 14:12

// mode register fields
`define SDH_MODE_WORD 11:0
`define SDH_MODE_FIRST 12
`define SDH_MODE_RESET 12'h020
`define SDH_MF_LAT 6:4
`define SDH_MF_BL 2:0
`define SDH_MF_SINGLE 9
`define SDH_BL_FULL 3'h7
`define SDH_FULL_PAGE 9'h100

// timing
`define SDH_HOLD_US 100
`define SDH_CLK_MHZ 100
`define SDH_REF_INIT 2'h2
`define SDH_MRS_GAP 4'h2
`define SDH_REF_GAP 4'h8
`define SDH_WAKE_GAP 4'h1
`define SDH_CMD_GAP 4'h0
`define SDH_PIPE_LAT 4'h3
`endif

// file: include/sdh_pkg.sv
package sdh_pkg;
  typedef enum logic [3:0] {
    SDH_OP_NOP = 4'h0,
    SDH_OP_BST = 4'h1,
    SDH_OP_READ = 4'h2,
    SDH_OP_WRITE = 4'h3,
    SDH_OP_ACT = 4'h4,
    SDH_OP_PRE = 4'h5,
    SDH_OP_REF = 4'h6,
    SDH_OP_MRS = 4'h7,
    SDH_OP_SLEEP = 4'h8,
    SDH_OP_WAKE = 4'h9
  } sdh_op_e;

  typedef enum logic [2:0] {
    BK_IDLE = 3'h0,
    BK_ACTIVE = 3'h1,
    BK_READ = 3'h2,
    BK_WRITE = 3'h3,
    BK_READ_AC = 3'h4,
    BK_WRITE_AC = 3'h5
  } sdh_bank_e;

  typedef enum logic [2:0] {
    S_HOLD = 3'h0,
    S_INIT = 3'h1,
    S_READY = 3'h2,
    S_SLEEP = 3'h3
  } sdh_state_e;

  typedef struct packed {
    sdh_op_e op;
    logic bank;
    logic a10;
    logic [10:0] addr;
  } sdh_req_s;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [11:0] addr;
  } sdh_pins_s;
endpackage : sdh_pkg

// file: rtl/sdh_bank_track.sv
`include "sdh_defs.svh"
module sdh_bank_track
  import sdh_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // issued command
  input wire logic issue,
  input sdh_req_s req,
  input wire logic burst_done,
  // mirrored bank states
  output sdh_bank_e bank_st [2]
);
  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic hit;
    assign hit = (req.bank == 1'(b));
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        bank_st[b] <= BK_IDLE;
      end else if (ce) begin
        if (issue) begin
          case (req.op)
            SDH_OP_ACT: begin
              if (hit) bank_st[b] <= BK_ACTIVE;
            end
            SDH_OP_READ: begin
              if (hit) bank_st[b] <= req.a10 ? BK_READ_AC : BK_READ;
              else if (bank_st[b] == BK_READ || bank_st[b] == BK_WRITE)
                bank_st[b] <= BK_ACTIVE;
            end
            SDH_OP_WRITE: begin
              if (hit) bank_st[b] <= req.a10 ? BK_WRITE_AC : BK_WRITE;
              else if (bank_st[b] == BK_READ || bank_st[b] == BK_WRITE)
                bank_st[b] <= BK_ACTIVE;
            end
            SDH_OP_PRE: begin
              if (req.a10 || hit) bank_st[b] <= BK_IDLE;
            end
            SDH_OP_BST: begin
              if (bank_st[b] == BK_READ || bank_st[b] == BK_WRITE)
                bank_st[b] <= BK_ACTIVE;
            end
            default: begin
            end
          endcase
        end else if (burst_done) begin
          if (bank_st[b] == BK_READ || bank_st[b] == BK_WRITE)
            bank_st[b] <= BK_ACTIVE;
          else if (bank_st[b] == BK_READ_AC || bank_st[b] == BK_WRITE_AC)
            bank_st[b] <= BK_IDLE;
        end
      end
    end
  end
endmodule : sdh_bank_track

// file: sim/sdh_mem_model.sv
module sdh_mem_model
  import sdh_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command pins
  input wire logic sd_cke,
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n,
  input wire logic [11:0] sd_addr,
  input wire logic [1:0] sd_dqm,
  // data wire
  input wire logic [15:0] dq,
  output logic [15:0] mdq,
  output logic moe,
  // observed state
  output logic [11:0] mword,
  output sdh_bank_e burst_stop_cmd [2],
  output int hold,
  output int nref,
  output int ref_at_load,
  output int first_op,
  output int viol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [10:0] row [2];
  logic [15:0] pd [16];
  logic [15:0] pv = 16'h0;
  logic [3:0] op;
  logic b, bb, wr, pcke;
  int len, cl, left, col, n, last_load, cyc;
  assign op = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  assign b = sd_addr[11];
  assign len = (mword[2:0] == 3'h7) ? 256 : (1 << mword[2:0]);
  assign cl = int'(mword[6:4]);
  assign mdq = pd[0];
  assign moe = pv[0];
  function automatic int key(logic k, int c);
    return {k, row[k], c[7:0]};
  endfunction : key
  function automatic int seq(int i);
    return mword[3] ? (col ^ i) : ((col & ~(len - 1)) | ((col + i) & (len - 1)));
  endfunction : seq
  task automatic end_burst(bit stop);
    if (left > 0)
      burst_stop_cmd[bb] = (burst_stop_cmd[bb] == BK_READ_AC || burst_stop_cmd[bb] == BK_WRITE_AC) ? BK_IDLE : BK_ACTIVE;
    left = 0;
    if (stop) pv <= 16'h0;
  endtask : end_burst
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pv <= 16'h0;
      mword = 12'h0;
      burst_stop_cmd = '{BK_IDLE, BK_IDLE};
      {hold, nref, ref_at_load, viol, left, cyc} = '0;
      first_op = -1;
      last_load = -10;
      pcke = 1'b1;
    end else begin
      pv <= pv >> 1;
      for (n = 0; n < 15; n++) pd[n] <= pd[n + 1];
      cyc++;
      if (first_op < 0 && sd_cs_n && sd_cke && sd_dqm == 2'h3) hold++;
      if (pcke && !sd_cke && (burst_stop_cmd[0] != BK_IDLE || burst_stop_cmd[1] != BK_IDLE)) viol++;
      pcke = sd_cke;
      if (left == 1) end_burst(1'b0);
      else if (left > 1) begin
        left--;
        if (wr && sd_dqm != 2'h3) mem[key(bb, seq(len - left))] = dq;
      end
      if (sd_cke && !sd_cs_n) begin
        if (first_op < 0) first_op = {sd_addr[10], op};
        if (cyc - last_load < 3) viol++;
        case (op)
          4'b0011: begin
            if (burst_stop_cmd[b] != BK_IDLE) viol++;
            burst_stop_cmd[b] = BK_ACTIVE;
            row[b] = sd_addr[10:0];
          end
          4'b0101, 4'b0100: begin
            if (burst_stop_cmd[b] == BK_IDLE) viol++;
            end_burst(1'b1);
            wr = !sd_we_n;
            bb = b;
            col = int'(sd_addr[7:0]);
            burst_stop_cmd[b] = wr ? (sd_addr[10] ? BK_WRITE_AC : BK_WRITE)
                        : (sd_addr[10] ? BK_READ_AC : BK_READ);
            left = (wr && mword[9]) ? 1 : len;
            if (wr && sd_dqm != 2'h3) mem[key(b, col)] = dq;
            for (n = 0; n < len && n < 8 && !wr; n++) begin
              pd[cl - 1 + n] <= mem.exists(key(b, seq(n))) ? mem[key(b, seq(n))] : 16'h0;
              pv[cl - 1 + n] <= 1'b1;
            end
          end
          4'b0010: begin
            if (sd_addr[10] || bb == b) end_burst(1'b1);
            if (sd_addr[10]) burst_stop_cmd = '{BK_IDLE, BK_IDLE};
            else burst_stop_cmd[b] = BK_IDLE;
          end
          4'b0001: begin
            if (burst_stop_cmd[0] != BK_IDLE || burst_stop_cmd[1] != BK_IDLE) viol++;
            nref++;
          end
          4'b0000: begin
            if (burst_stop_cmd[0] != BK_IDLE || burst_stop_cmd[1] != BK_IDLE) viol++;
            mword = sd_addr;
            ref_at_load = nref;
            last_load = cyc;
          end
          4'b0110: end_burst(1'b1);
          default: ;
        endcase
      end
    end
  end
endmodule : sdh_mem_model

// file: sim/tb_sdram_two_bank_command_mode.sv
`include "sdh_defs.svh"
module tb_sdram_two_bank_command_mode
  import sdh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe_n, moe, slp;
  logic [11:0] sd_addr, mword;
  logic [1:0] sd_dqm;
  logic [15:0] sd_dq_out, mdq, dq;
  logic [15:0] dq_last = 16'h0;
  logic [10:0] row [2];
  logic [15:0] emem [int];
  logic [11:0] modes [4] = '{12'h022, 12'h03b, 12'h233, 12'h031};
  sdh_bank_e burst_stop_cmd [2];
  int hold, nref, ref_at_load, first_op, viol, r, c;
  int bk [2];
  int failures = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;
  // released wire shows the inverse of its last level
  assign dq = moe ? mdq : (!sd_dq_oe_n ? sd_dq_out : ~dq_last);
  always @(posedge clk) dq_last <= dq;

  sdh_host #(.HOLD_CYC(20)) uut (.clk, .nrst, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .sd_cke, .sd_cs_n, .sd_ras_n,
    .sd_cas_n, .sd_we_n, .sd_addr, .sd_dqm, .sd_dq_in(dq), .sd_dq_out, .sd_dq_oe_n);
  sdh_mem_model mem (.clk, .nrst, .sd_cke, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n,
    .sd_addr, .sd_dqm, .dq, .mdq, .moe, .mword, .burst_stop_cmd, .hold, .nref, .ref_at_load,
    .first_op, .viol);

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic av(input bit w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
  endtask : av

  task automatic poll(input logic [31:0] mask, input logic [31:0] want);
    int n;
    n = 0;
    do begin
      av(1'b0, `SDH_REG_STATUS, 32'h0);
      n++;
    end while ((q & mask) !== want && n < 40);
    if ((q & mask) !== want) begin
      failures++;
      print_verdict();
    end
  endtask : poll

  task automatic boot(input bit load_first, input logic [31:0] mode);
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bk = '{0, 0};
    slp = 1'b0;
    if (load_first) av(1'b1, `SDH_REG_MODE, mode);
    poll(32'h1, 32'h1);
    chk(first_op, 32'h12);
    chk(32'(nref >= 2), 32'h1);
    chk(ref_at_load, load_first ? 32'h0 : 32'h2);
    chk(32'(hold >= 20), 32'h1);
    chk(mword, mode[11:0]);
  endtask : boot

  task automatic do_cmd(input logic [3:0] op, input bit b, a10, input logic [10:0] ad);
    bit bad, rd;
    int k;
    logic [31:0] d;
    bad = 1'b0;
    case (op)
      4'h4: if (bk[b] != 0) bad = 1'b1; else begin bk[b] = 1; row[b] = ad; end
      4'h2, 4'h3: if (bk[b] == 0) bad = 1'b1; else bk[b] = a10 ? 0 : 1;
      4'h5: if (a10) bk = '{0, 0}; else bk[b] = 0;
      4'h6, 4'h7, 4'h8: bad = (bk[0] != 0 || bk[1] != 0);
      4'h9: bad = !slp;
      default: ;
    endcase
    if (op == 4'h8 && !bad) slp = 1'b1;
    if (op == 4'h9) slp = 1'b0;
    rd = (op == 4'h2 && !bad);
    k = {b, row[b], ad[7:0]};
    d = $urandom;
    if (op == 4'h3 && !bad) av(1'b1, `SDH_REG_WDATA, d);
    if (op == 4'h3 && !bad) emem[k] = d[15:0];
    av(1'b1, `SDH_REG_CMD, {13'h0, ad, 2'h0, a10, b, op});
    poll(slp ? 32'h6608 : (rd ? 32'h6612 : 32'h6602), slp ? 32'h8 : (rd ? 32'h10 : 32'h0));
    chk(q[`SDH_ST_ERR], bad);
    chk(q[`SDH_ST_BANK0], bk[0]);
    chk(q[`SDH_ST_BANK1], bk[1]);
    chk(burst_stop_cmd[b], bk[b]);
    if (rd) av(1'b0, `SDH_REG_RDATA, 32'h0);
    if (rd) chk(q[15:0], emem.exists(k) ? emem[k] : 16'h0);
    if (bad) av(1'b1, `SDH_REG_STATUS, 32'h4);
  endtask : do_cmd

  initial begin
    void'($urandom(88));
    boot(1'b0, 32'h020);
    av(1'b0, `SDH_REG_MODE, 32'h0);
    chk(q, 32'h020);
    av(1'b1, 3'h7, 32'h5a);
    av(1'b0, 3'h7, 32'h0);
    chk(q, 32'h0);
    foreach (modes[m]) begin
      av(1'b1, `SDH_REG_MODE, {20'h0, modes[m]});
      do_cmd(4'h7, 1'b0, 1'b0, 11'h0);
      chk(mword, modes[m]);
      for (int b = 0; b < 2; b++) begin
        r = $urandom;
        c = $urandom;
        do_cmd(4'h4, b[0], r[10], r[10:0]);
        do_cmd(4'h4, b[0], 1'b0, 11'h0);
        do_cmd(4'h7, 1'b0, 1'b0, 11'h0);
        do_cmd(4'h3, b[0], 1'b0, {1'b0, c[9:0]});
        do_cmd(4'h2, b[0], 1'b0, {1'b0, ~c[9:8], c[7:0]});
        do_cmd(4'h3, b[0], 1'b1, c[10:0] & 11'h3ff);
        do_cmd(4'h2, b[0], 1'b0, 11'h0);
      end
      do_cmd(4'h5, 1'b0, 1'b1, 11'h0);
    end
    do_cmd(4'h4, 1'b0, 1'b0, 11'h15);
    do_cmd(4'h4, 1'b1, 1'b0, 11'h34);
    do_cmd(4'h3, 1'b0, 1'b0, 11'h40);
    do_cmd(4'h8, 1'b0, 1'b0, 11'h0);
    do_cmd(4'h5, 1'b1, 1'b0, 11'h0);
    do_cmd(4'h5, 1'b0, 1'b1, 11'h0);
    do_cmd(4'h9, 1'b0, 1'b0, 11'h0);
    do_cmd(4'h8, 1'b0, 1'b0, 11'h0);
    chk(sd_cke, 1'b0);
    do_cmd(4'h9, 1'b0, 1'b0, 11'h0);
    chk(sd_cke, 1'b1);
    av(1'b1, `SDH_REG_MODE, 32'h027);
    do_cmd(4'h7, 1'b0, 1'b0, 11'h0);
    do_cmd(4'h4, 1'b0, 1'b0, 11'h15);
    av(1'b1, `SDH_REG_CMD, {13'h0, 11'h40, 8'h02});
    do_cmd(4'h1, 1'b0, 1'b0, 11'h0);
    poll(32'h10, 32'h10);
    av(1'b0, `SDH_REG_RDATA, 32'h0);
    chk(q[15:0], emem[{1'b0, 11'h15, 8'h40}]);
    do_cmd(4'h5, 1'b0, 1'b1, 11'h0);
    chk(viol, 32'h0);
    boot(1'b1, 32'h1020);
    chk(viol, 32'h0);
    print_verdict();
  end
endmodule : tb_sdram_two_bank_command_mode
